//--- logic/usw_map.svh
// Constants for the serial wire mode and clock select block
// Notes on behaviour
// - Wire mode changes only output pin behaviour and the start flag source
// - External clocking and sampling work with outputs off
// - Mode 00: outputs, hold, start detector off
// - Mode 01: shift output replaces data-out port bit
// - Three-wire: data-in and clock pins stay normal
// - Two-wire: open-drain lines, driver gated by direction
// - SDA low when shift MSB or port zero
// - SCL low when port zero or start hold
// - Start detected: hold SCL until flag cleared
// - Two-wire: inputs unchanged, pull-ups forced off
// - Mode 11: also hold SCL after overflow
// - External clock: output changes on opposite edge
// - Strobe or timer source: output latch transparent
// - Source 00: clocked only by strobe write
// - Source 01: timer match clocks both
// - Source 1x: shift on chosen edge, count both
// - Source 1x, strobe set: counter on toggle strobe
// - Toggle strobe inverts clock port bit, reads zero
// - Overflow flag set on wrap 15 to 0
// - Start flag cleared only by writing one
`ifndef USW_MAP_SVH
`define USW_MAP_SVH

// Counter value at which the next count wraps
`define USW_CNT_TOP      4'hF
// Reset values
`define USW_CNT_RST      4'h0
`define USW_DATA_RST     8'h00
`define USW_WM_RST       2'h0
`define USW_CS_RST       2'h0
// Position of the shift register output bit
`define USW_DATA_MSB     7
// Synchroniser depth on pin inputs
`define USW_SYNC_STAGES  2

`endif

//--- logic/usw_pkg.sv
// Types shared by the serial wire mode and clock select block
package usw_pkg;

  // Wire mode field codes, in field order 00..11
  typedef enum logic [1:0] {
    USW_WM_OFF,
    USW_WM_THREE,
    USW_WM_TWO,
    USW_WM_TWO_OVF
  } usw_wire_mode_t;

  // Clock source field codes, in field order 00..11
  typedef enum logic [1:0] {
    USW_CS_STROBE,
    USW_CS_TIMER,
    USW_CS_EXT_POS,
    USW_CS_EXT_NEG
  } usw_clk_src_t;

endpackage : usw_pkg

//--- logic/usw_edge_if.sv
// Synchronised pin level with its edge pulses
`timescale 1ns/1ps
interface usw_edge_if;
  logic level;  // Synchronised pin level
  logic rise;   // One-cycle pulse on a rising edge
  logic fall;   // One-cycle pulse on a falling edge
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : usw_edge_if

//--- logic/usw_sync_edge.sv
// Two-flop synchroniser with edge detector for one pin
`timescale 1ns/1ps
`include "usw_map.svh"
module usw_sync_edge (
  // Clock, enable and reset
  input  wire logic core_clk,
  input  wire logic clk_en,
  input  wire logic rst_int_n,
  // Asynchronous pin level
  input  wire logic pin_async,
  // Synchronised result
  usw_edge_if.src   edge_o
);
  import usw_pkg::*;

  // ************************************
  // Synchroniser and edge history
  // ************************************
  logic [`USW_SYNC_STAGES-1:0] sync_q;  // Stage 0 feeds only stage 1
  logic                        prev_q;  // Last synchronised level

  // Sync chain; first flop is read only by the second
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      sync_q <= '0;
    end else if (clk_en) begin
      sync_q <= {sync_q[`USW_SYNC_STAGES-2:0], pin_async};
    end
  end

  // Edge history taken from the last stage only
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      prev_q <= 1'b0;
    end else if (clk_en) begin
      prev_q <= sync_q[`USW_SYNC_STAGES-1];
    end
  end

  // Pulses last exactly one enabled cycle, so each edge acts once
  assign edge_o.level = sync_q[`USW_SYNC_STAGES-1];
  assign edge_o.rise  = clk_en & sync_q[`USW_SYNC_STAGES-1] & ~prev_q;
  assign edge_o.fall  = clk_en & ~sync_q[`USW_SYNC_STAGES-1] & prev_q;

endmodule : usw_sync_edge

//--- logic/usw_wire_clock.sv
// Wire mode output control and shift/counter clock selection
`timescale 1ns/1ps
`include "usw_map.svh"
module usw_wire_clock (
  // Clock, enable and reset
  input  wire logic                  core_clk,
  input  wire logic                  clk_en,
  input  wire logic                  rst_n,
  // Control write: one-cycle pulse with field values
  input  wire logic                  ctrl_wr,
  input  wire usw_pkg::usw_wire_mode_t wire_mode_sel,
  input  wire usw_pkg::usw_clk_src_t clock_source_sel,
  input  wire logic                  clock_strobe_bit,
  input  wire logic                  toggle_clock_strobe,
  // Control readback, strobe bits always zero
  output      logic [5:0]            ctrl_rdata,
  // Flag clears, write-one pulses
  input  wire logic                  start_flag_clr,
  input  wire logic                  ovf_flag_clr,
  // Status flags and counter
  output      logic                  start_cond_flag,
  output      logic                  counter_overflow_flag,
  output      logic [3:0]            cnt_value,
  input  wire logic                  cnt_wr,
  input  wire logic [3:0]            cnt_wdata,
  // Shift register access
  output      logic [7:0]            data_value,
  input  wire logic                  data_wr,
  input  wire logic [7:0]            data_wdata,
  // Timer compare match, one-cycle pulse on core_clk
  input  wire logic                  timer0_match,
  // Port and direction bits of the three pins
  input  wire logic                  port_do_bit,
  input  wire logic                  ddr_do_bit,
  input  wire logic                  port_di_bit,
  input  wire logic                  ddr_di_bit,
  input  wire logic                  ddr_clk_bit,
  input  wire logic                  port_clk_wr,
  input  wire logic                  port_clk_wdata,
  output      logic                  port_clk_bit,
  // Data-out pin
  output      logic                  do_pin_o,
  output      logic                  do_pin_oe,
  output      logic                  do_pin_pullup,
  // Data-in / SDA pin
  input  wire logic                  serial_data_in_pin,
  output      logic                  sda_pin_o,
  output      logic                  sda_pin_oe,
  output      logic                  sda_pin_pullup,
  // Clock / SCL pin
  input  wire logic                  serial_clock_pin,
  output      logic                  scl_pin_o,
  output      logic                  scl_pin_oe,
  output      logic                  scl_pin_pullup
);
  import usw_pkg::*;

  // ************************************
  // Reset release
  // ************************************
  logic [1:0] rst_sync_q;  // Release shift chain
  logic       rst_int_n;   // Synchronised reset used everywhere

  // Assert at once, release after two edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_q[1];

  // ************************************
  // Pin input synchronisers
  // ************************************
  usw_edge_if scl_e ();  // Serial clock pin
  usw_edge_if sda_e ();  // Serial data pin

  usw_sync_edge u_scl_sync (
    .core_clk  (core_clk),
    .clk_en    (clk_en),
    .rst_int_n (rst_int_n),
    .pin_async (serial_clock_pin),
    .edge_o    (scl_e)
  );

  // Data input sampled in every mode
  usw_sync_edge u_sda_sync (
    .core_clk  (core_clk),
    .clk_en    (clk_en),
    .rst_int_n (rst_int_n),
    .pin_async (serial_data_in_pin),
    .edge_o    (sda_e)
  );

  // ************************************
  // Control fields
  // ************************************
  usw_wire_mode_t wm_q;       // Wire mode
  usw_clk_src_t   cs_q;       // Clock source
  logic           ext_sel_q;  // Counter on toggle strobe in external modes
  logic           two_wire;   // Either two-wire mode
  logic           ext_src;    // External clock source selected

  // Fields load on a control write
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      wm_q      <= usw_wire_mode_t'(`USW_WM_RST);
      cs_q      <= usw_clk_src_t'(`USW_CS_RST);
      ext_sel_q <= 1'b0;
    end else if (clk_en && ctrl_wr) begin
      wm_q      <= wire_mode_sel;
      cs_q      <= clock_source_sel;
      ext_sel_q <= clock_strobe_bit;
    end
  end

  assign ctrl_rdata = {wm_q, cs_q, 2'h0};
  // Mode and source decodes used throughout
  assign two_wire   = (wm_q == USW_WM_TWO) || (wm_q == USW_WM_TWO_OVF);
  assign ext_src    = (cs_q == USW_CS_EXT_POS) || (cs_q == USW_CS_EXT_NEG);

  // ************************************
  // Clock selection
  // ************************************
  logic strobe_go;   // Software strobe written with source 00
  logic toggle_go;   // Toggle strobe written
  logic shift_tick;  // Shift register clock
  logic cnt_tick;    // Counter clock
  logic samp_edge;   // External sampling edge

  assign strobe_go = ctrl_wr & clock_strobe_bit & (clock_source_sel == USW_CS_STROBE);
  assign toggle_go = ctrl_wr & toggle_clock_strobe;
  assign samp_edge = (cs_q == USW_CS_EXT_NEG) ? scl_e.fall : scl_e.rise;

  // Source decode; inputs work whatever the wire mode
  always_comb begin
    shift_tick = 1'b0;
    cnt_tick   = 1'b0;
    unique case (cs_q)
      USW_CS_STROBE: begin
        shift_tick = strobe_go;
        cnt_tick   = strobe_go;
      end
      USW_CS_TIMER: begin
        shift_tick = timer0_match;
        cnt_tick   = timer0_match;
      end
      // chosen edge shifts, both edges count
      USW_CS_EXT_POS, USW_CS_EXT_NEG: begin
        shift_tick = samp_edge;
        cnt_tick   = ext_sel_q ? toggle_go : (scl_e.rise | scl_e.fall);
      end
    endcase
    // A write that selects source 00 with the strobe clocks at once
    if (strobe_go) begin
      shift_tick = 1'b1;
      cnt_tick   = 1'b1;
    end
  end

  // ************************************
  // Shift register and counter
  // ************************************
  logic [7:0] data_q;  // Shift register
  logic [3:0] cnt_q;   // 4-bit counter
  logic       wrap;    // Counter wraps this cycle

  // shifts from synced input in any wire mode
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      data_q <= `USW_DATA_RST;
    end else if (clk_en) begin
      // A write beats a shift in the same cycle
      if (data_wr) begin
        data_q <= data_wdata;
      end else if (shift_tick) begin
        data_q <= {data_q[6:0], sda_e.level};
      end
    end
  end

  // Overflow only on a real count from the top value
  assign wrap = cnt_tick & ~cnt_wr & (cnt_q == `USW_CNT_TOP);

  // Counter; a write beats a count
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cnt_q <= `USW_CNT_RST;
    end else if (clk_en) begin
      if (cnt_wr) begin
        cnt_q <= cnt_wdata;
      end else if (cnt_tick) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // Register values go straight to the status ports
  assign data_value = data_q;
  assign cnt_value  = cnt_q;

  // ************************************
  // Flags and start detector
  // ************************************
  logic start_q;   // Start condition flag
  logic ovf_q;     // Counter overflow flag
  logic start_ev;  // Start condition or count, per mode

  // detector off in mode 00; count event in three-wire
  always_comb begin
    start_ev = 1'b0;
    if (two_wire) begin
      start_ev = sda_e.fall & scl_e.level;
    end else if (wm_q == USW_WM_THREE) begin
      start_ev = cnt_tick & ~cnt_wr;
    end
  end

  // cleared only by write-one; set wins
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      start_q <= 1'b0;
    end else if (clk_en) begin
      if (start_ev) begin
        start_q <= 1'b1;
      end else if (start_flag_clr) begin
        start_q <= 1'b0;
      end
    end
  end

  // set on wrap 15 to 0; set wins over clear
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      ovf_q <= 1'b0;
    end else if (clk_en) begin
      if (wrap) begin
        ovf_q <= 1'b1;
      end else if (ovf_flag_clr) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // Flag outputs come straight from flops
  assign start_cond_flag       = start_q;
  assign counter_overflow_flag = ovf_q;

  // ************************************
  // Clock port bit
  // ************************************
  logic port_clk_q;  // Clock pin port value

  // toggle strobe inverts it, direction ignored
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      port_clk_q <= 1'b0;
    end else if (clk_en) begin
      if (toggle_go) begin
        port_clk_q <= ~port_clk_q;
      end else if (port_clk_wr) begin
        port_clk_q <= port_clk_wdata;
      end
    end
  end
  // Held here so the toggle strobe can act on it
  assign port_clk_bit = port_clk_q;

  // ************************************
  // Output latch
  // ************************************
  logic latch_q;  // Held shift register MSB
  logic transp;   // Latch open
  logic msb_out;  // Value toward the data pin

  // internal sources keep the latch open
  // external: open only in the half before the sampling edge
  assign transp  = ~ext_src | (scl_e.level == (cs_q == USW_CS_EXT_NEG));
  assign msb_out = transp ? data_q[`USW_DATA_MSB] : latch_q;

  // Latch follows the MSB while open, holds it otherwise
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      latch_q <= 1'b0;
    end else if (clk_en && transp) begin
      latch_q <= data_q[`USW_DATA_MSB];
    end
  end

  // ************************************
  // Pin drivers
  // ************************************
  logic scl_hold;  // Start or overflow hold of SCL

  // mode 11 also holds on overflow
  assign scl_hold = two_wire & (start_q | ((wm_q == USW_WM_TWO_OVF) & ovf_q));

  // mode steers outputs only; inputs untouched
  always_comb begin
    // Plain port behaviour by default
    do_pin_o       = port_do_bit;
    do_pin_oe      = ddr_do_bit;
    do_pin_pullup  = ~ddr_do_bit & port_do_bit;
    sda_pin_o      = port_di_bit;
    sda_pin_oe     = ddr_di_bit;
    sda_pin_pullup = ~ddr_di_bit & port_di_bit;
    scl_pin_o      = port_clk_q;
    scl_pin_oe     = ddr_clk_bit;
    scl_pin_pullup = ~ddr_clk_bit & port_clk_q;
    unique case (wm_q)
      USW_WM_OFF: begin
      end
      USW_WM_THREE: begin
        do_pin_o = msb_out;
      end
      USW_WM_TWO, USW_WM_TWO_OVF: begin
        // SDA low on MSB or port zero
        sda_pin_o      = 1'b0;
        sda_pin_oe     = ddr_di_bit & (~msb_out | ~port_di_bit);
        // SCL low on port zero or hold
        scl_pin_o      = 1'b0;
        scl_pin_oe     = ddr_clk_bit & (~port_clk_q | scl_hold);
        sda_pin_pullup = 1'b0;
        scl_pin_pullup = 1'b0;
      end
    endcase
  end

endmodule : usw_wire_clock

//--- testbench/usw_wire_clock_props.sv
// Concurrent checks on the ports of the wire mode and clock select block
`timescale 1ns/1ps
module usw_wire_clock_props (
  // Clock, enable and reset
  input wire logic                 core_clk,
  input wire logic                 clk_en,
  input wire logic                 rst_n,
  // Control write and readback
  input wire logic                 ctrl_wr,
  input wire usw_pkg::usw_clk_src_t clock_source_sel,
  input wire logic                 clock_strobe_bit,
  input wire logic                 toggle_clock_strobe,
  input wire logic [5:0]           ctrl_rdata,
  // Flags, counter, shift register
  input wire logic                 start_flag_clr,
  input wire logic                 start_cond_flag,
  input wire logic                 counter_overflow_flag,
  input wire logic [3:0]           cnt_value,
  input wire logic                 cnt_wr,
  input wire logic [7:0]           data_value,
  input wire logic                 timer0_match,
  // Port bits
  input wire logic                 port_do_bit,
  input wire logic                 ddr_do_bit,
  input wire logic                 port_di_bit,
  input wire logic                 ddr_di_bit,
  input wire logic                 ddr_clk_bit,
  input wire logic                 port_clk_wr,
  input wire logic                 port_clk_bit,
  // Pin controls
  input wire logic                 do_pin_o,
  input wire logic                 do_pin_oe,
  input wire logic                 do_pin_pullup,
  input wire logic                 sda_pin_o,
  input wire logic                 sda_pin_oe,
  input wire logic                 sda_pin_pullup,
  input wire logic                 scl_pin_oe,
  input wire logic                 scl_pin_pullup
);
  import usw_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Last count before a wrap, then the wrapped value
  sequence s_wrap;
    clk_en && cnt_value == 4'hF && !cnt_wr ##1 cnt_value == 4'h0;
  endsequence

  a_off_plain: assert property (ctrl_rdata[5:4] == 2'b00 && $past(ctrl_rdata[5:4]) == 2'b00
    |-> do_pin_o == port_do_bit && !$rose(start_cond_flag))
    else $error("mode off pin not plain");
  a_three_wire_dir: assert property (ctrl_rdata[5:4] == 2'b01 |-> do_pin_oe == ddr_do_bit
    && do_pin_pullup == (!ddr_do_bit && port_do_bit))
    else $error("three-wire direction or pull-up wrong");
  a_two_sda_drive: assert property (ctrl_rdata[5] && !ctrl_rdata[3] |-> !sda_pin_o
    && sda_pin_oe == (ddr_di_bit && (!data_value[7] || !port_di_bit)))
    else $error("sda drive wrong");
  a_two_scl_drive: assert property (ctrl_rdata[5] |-> scl_pin_oe == (ddr_clk_bit && (!port_clk_bit
    || start_cond_flag || (ctrl_rdata[4] && counter_overflow_flag))))
    else $error("scl drive wrong");
  a_pullups_off: assert property (ctrl_rdata[5] |-> !sda_pin_pullup && !scl_pin_pullup)
    else $error("pull-up on in two-wire");
  a_toggle_inverts: assert property (clk_en && ctrl_wr && toggle_clock_strobe && !port_clk_wr
    |=> port_clk_bit != $past(port_clk_bit) && ctrl_rdata[1:0] == 2'b00)
    else $error("toggle strobe did not invert");
  a_ovf_on_wrap: assert property (s_wrap |-> counter_overflow_flag)
    else $error("no overflow flag on wrap");
  a_start_sticky: assert property (start_cond_flag && !start_flag_clr |=> start_cond_flag)
    else $error("start flag lost without clear");
  a_strobe_count: assert property (clk_en && ctrl_wr && clock_source_sel == USW_CS_STROBE
    && clock_strobe_bit && !cnt_wr |=> cnt_value == $past(cnt_value) + 4'h1)
    else $error("strobe did not count");
  a_timer_count: assert property (clk_en && timer0_match && !ctrl_wr && !cnt_wr
    && ctrl_rdata[3:2] == 2'b01 |=> cnt_value == $past(cnt_value) + 4'h1)
    else $error("timer match did not count");
  a_src_idle: assert property (ctrl_rdata[3:2] == 2'b00 && !ctrl_wr && !cnt_wr |=> $stable(cnt_value))
    else $error("counter moved with no clock");
endmodule : usw_wire_clock_props

bind usw_wire_clock usw_wire_clock_props u_props (.core_clk, .clk_en, .rst_n, .ctrl_wr, .clock_source_sel,
  .clock_strobe_bit, .toggle_clock_strobe, .ctrl_rdata, .start_flag_clr, .start_cond_flag,
  .counter_overflow_flag, .cnt_value, .cnt_wr, .data_value, .timer0_match, .port_do_bit, .ddr_do_bit,
  .port_di_bit, .ddr_di_bit, .ddr_clk_bit, .port_clk_wr, .port_clk_bit, .do_pin_o, .do_pin_oe,
  .do_pin_pullup, .sda_pin_o, .sda_pin_oe, .sda_pin_pullup, .scl_pin_oe, .scl_pin_pullup);

//--- testbench/usw_peer.sv
// Behavioural serial peer driving the clock and data lines
`timescale 1ns/1ps
module usw_peer (
  // Line levels offered by the peer
  output logic scl_line,
  output logic sda_line
);
  initial begin
    scl_line = 1'b0;
    sda_line = 1'b1;
  end
  // bit period 160 ns, clock high for the middle half of the bit
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_line = b[i];
      #40;
      scl_line = 1'b1;
      #80;
      scl_line = 1'b0;
      #40;
    end
    // Released data shows the inverse; clock stands still low
    sda_line = ~b[0];
  endtask : send_byte
  // Data falls while clock is high
  task automatic start_cond();
    scl_line = 1'b1;
    sda_line = 1'b1;
    #80;
    sda_line = 1'b0;
    #80;
  endtask : start_cond
  // Park the clock line at a level between frames
  task automatic set_clk(input logic v);
    scl_line = v;
  endtask : set_clk
endmodule : usw_peer

//--- testbench/tb_usw_wire_clock.sv
// Self-checking bench for the wire mode and clock select block
`timescale 1ns/1ps
module tb_usw_wire_clock;
  import usw_pkg::*;
  logic core_clk, clk_en, rst_n, ctrl_wr, clock_strobe_bit, toggle_clock_strobe, start_flag_clr, ovf_flag_clr;
  logic cnt_wr, data_wr, timer0_match, port_do_bit, ddr_do_bit, port_di_bit, ddr_di_bit, ddr_clk_bit;
  logic port_clk_wr, port_clk_wdata, port_clk_bit, start_cond_flag, counter_overflow_flag;
  logic do_pin_o, do_pin_oe, do_pin_pullup, sda_pin_o, sda_pin_oe, sda_pin_pullup, scl_pin_o, scl_pin_oe;
  logic scl_pin_pullup, serial_data_in_pin, serial_clock_pin, p_sda, p_scl;
  usw_wire_mode_t wire_mode_sel;
  usw_clk_src_t   clock_source_sel;
  logic [5:0]     ctrl_rdata;
  logic [3:0]     cnt_value, cnt_wdata;
  logic [7:0]     data_value, data_wdata;
  int             err_count, total_checks;

  // Wire level: a driving pin wins over the peer
  assign serial_data_in_pin = sda_pin_oe ? sda_pin_o : p_sda;
  assign serial_clock_pin   = scl_pin_oe ? scl_pin_o : p_scl;

  usw_wire_clock dut (.core_clk, .clk_en, .rst_n, .ctrl_wr, .wire_mode_sel, .clock_source_sel,
    .clock_strobe_bit, .toggle_clock_strobe, .ctrl_rdata, .start_flag_clr, .ovf_flag_clr, .start_cond_flag,
    .counter_overflow_flag, .cnt_value, .cnt_wr, .cnt_wdata, .data_value, .data_wr, .data_wdata, .timer0_match,
    .port_do_bit, .ddr_do_bit, .port_di_bit, .ddr_di_bit, .ddr_clk_bit, .port_clk_wr, .port_clk_wdata,
    .port_clk_bit, .do_pin_o, .do_pin_oe, .do_pin_pullup, .serial_data_in_pin, .sda_pin_o, .sda_pin_oe,
    .sda_pin_pullup, .serial_clock_pin, .scl_pin_o, .scl_pin_oe, .scl_pin_pullup);
  usw_peer u_peer (.scl_line(p_scl), .sda_line(p_sda));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic conclude();
    if (err_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr_ctrl(input logic [1:0] m, input logic [1:0] c, input logic s, input logic t);
    wire_mode_sel = usw_wire_mode_t'(m);
    clock_source_sel = usw_clk_src_t'(c);
    clock_strobe_bit = s;
    toggle_clock_strobe = t;
    ctrl_wr = 1'b1;
    tick();
    ctrl_wr = 1'b0;
    toggle_clock_strobe = 1'b0;
  endtask : wr_ctrl

  task automatic wr_data(input logic [7:0] v);
    data_wdata = v;
    data_wr = 1'b1;
    tick();
    data_wr = 1'b0;
  endtask : wr_data

  task automatic wr_cnt(input logic [3:0] v);
    cnt_wdata = v;
    cnt_wr = 1'b1;
    ovf_flag_clr = 1'b1;
    start_flag_clr = 1'b1;
    tick();
    {cnt_wr, ovf_flag_clr, start_flag_clr} = 3'b000;
  endtask : wr_cnt

  // Watchdog: the tests need well under 200 us
  initial begin
    #200000;
    err_count++;
    conclude();
  end

  initial begin
    {clk_en, rst_n, ctrl_wr, clock_strobe_bit, toggle_clock_strobe, start_flag_clr, ovf_flag_clr} = 7'h40;
    {cnt_wr, data_wr, timer0_match, port_do_bit, ddr_do_bit, port_di_bit, ddr_di_bit, ddr_clk_bit} = 8'h04;
    {port_clk_wr, port_clk_wdata, cnt_wdata, data_wdata} = 14'h0000;
    wire_mode_sel = USW_WM_OFF;
    clock_source_sel = USW_CS_STROBE;
    tick(8);
    rst_n = 1'b1;
    tick(3);
    chk({port_clk_bit, start_cond_flag, counter_overflow_flag, cnt_value, 1'b0}, 8'h00);
    chk({2'b00, ctrl_rdata} | data_value, 8'h00);
    // Software strobe in mode off
    wr_data(8'hA5);
    wr_ctrl(2'b00, 2'b00, 1'b1, 1'b0);
    chk(data_value, 8'h4B);
    chk({3'b000, start_cond_flag, cnt_value}, 8'h01);
    // Timer source in three-wire mode
    ddr_do_bit = 1'b1;
    wr_ctrl(2'b01, 2'b01, 1'b0, 1'b0);
    wr_data(8'h80);
    chk({7'h00, do_pin_o}, 8'h01);
    chk({do_pin_oe, do_pin_pullup, ctrl_rdata}, 8'h94);
    chk({2'b00, sda_pin_o, sda_pin_oe, sda_pin_pullup, scl_pin_o, scl_pin_oe, scl_pin_pullup}, 8'h28);
    // Match held over four edges; the enable freezes the last one
    timer0_match = 1'b1;
    for (int i = 0; i < 4; i++) begin
      clk_en = (i != 3);
      tick();
    end
    timer0_match = 1'b0;
    clk_en = 1'b1;
    chk({4'h0, cnt_value}, 8'h04);
    chk({do_pin_o, data_value[6:0]}, 8'h07);
    // External edges, both polarities, outputs off
    wr_ctrl(2'b00, 2'b10, 1'b0, 1'b0);
    wr_cnt(4'h0);
    u_peer.send_byte(8'hC3);
    tick(4);
    chk(data_value, 8'hC3);
    chk({start_cond_flag, counter_overflow_flag, 2'b00, cnt_value}, 8'h40);
    wr_ctrl(2'b00, 2'b11, 1'b0, 1'b0);
    wr_cnt(4'h8);
    u_peer.send_byte(8'h5A);
    tick(4);
    chk(data_value, 8'h5A);
    chk({counter_overflow_flag, 3'b000, cnt_value}, 8'h88);
    // Counter on toggle writes, shift stays external
    wr_ctrl(2'b00, 2'b10, 1'b1, 1'b0);
    wr_cnt(4'hE);
    // software makes the clock by toggling; an idle edge between strobes
    for (int i = 0; i < 4; i++) begin
      wr_ctrl(2'b00, 2'b10, 1'b1, 1'b1);
      chk({7'h00, port_clk_bit}, (i % 2 == 0) ? 8'h01 : 8'h00);
      tick();
    end
    chk({counter_overflow_flag, 3'b000, cnt_value}, 8'h82);
    u_peer.send_byte(8'h3C);
    tick(4);
    chk(data_value ^ {4'h0, cnt_value}, 8'h3E);
    // Three-wire, external clock: latch holds while the clock is high
    wr_ctrl(2'b01, 2'b10, 1'b1, 1'b0);
    wr_data(8'h80);
    u_peer.set_clk(1'b1);
    tick(4);
    chk({6'h00, do_pin_o, data_value[7]}, 8'h02);
    u_peer.set_clk(1'b0);
    tick(4);
    chk({do_pin_o, data_value[6:0]}, 8'h01);
    // Two-wire with overflow hold and start hold
    port_clk_wdata = 1'b1;
    port_clk_wr = 1'b1;
    tick();
    port_clk_wr = 1'b0;
    {ddr_di_bit, ddr_clk_bit} = 2'b11;
    wr_ctrl(2'b11, 2'b00, 1'b0, 1'b0);
    wr_data(8'hFF);
    chk({6'h00, sda_pin_oe, scl_pin_oe}, 8'h01);
    chk({ctrl_rdata, sda_pin_o, scl_pin_o}, 8'hC0);
    ovf_flag_clr = 1'b1;
    tick();
    ovf_flag_clr = 1'b0;
    chk({5'h00, scl_pin_oe, sda_pin_pullup, scl_pin_pullup}, 8'h00);
    u_peer.start_cond();
    tick(4);
    chk({6'h00, start_cond_flag, scl_pin_oe}, 8'h03);
    tick(20);
    chk({6'h00, start_cond_flag, scl_pin_oe}, 8'h03);
    start_flag_clr = 1'b1;
    tick();
    start_flag_clr = 1'b0;
    wr_data(8'h7F);
    chk({5'h00, start_cond_flag, scl_pin_oe, sda_pin_oe}, 8'h01);
    conclude();
  end
endmodule : tb_usw_wire_clock
